// ---- otp_opt_pkg.sv ----
package otp_opt_pkg;
  localparam logic [7:0] OFF_BANK0 = 8'hc4;
  localparam logic [7:0] OFF_BANK1 = 8'hc5;
  localparam logic [7:0] OFF_BANK2 = 8'hc6;
  localparam logic [7:0] OFF_STATUS = 8'hd0;
  localparam logic [7:0] OFF_CTRL = 8'hd1;
  localparam logic [7:0] BANK0_RST = 8'h00;
  localparam logic [7:0] BANK1_RST = 8'h00;
  localparam logic [7:0] BANK2_RST = 8'h00;
  localparam int B0_DIR = 7;
  localparam int B0_REL = 6;
  localparam int B0_POL = 5;
  localparam int B0_TTHR_LO = 2;
  localparam int B0_PTHR_LO = 0;
  localparam int B1_HALT_LO = 6;
  localparam int B1_FAST = 3;
  localparam int B1_BASE_LO = 0;
  localparam int B2_TUNE = 2;
  localparam logic [7:0] B1_USED_MASK = 8'hcf;
  localparam logic [7:0] B2_USED_MASK = 8'hef;
  localparam logic [1:0] HALT_20S = 2'h0;
  localparam logic [1:0] HALT_40S = 2'h1;
  localparam logic [1:0] HALT_NEVER = 2'h2;
  localparam logic [1:0] HALT_3S = 2'h3;
  localparam int CLK_HZ = 125_000_000;
  localparam longint HALT_20S_SEC = 20;
  localparam longint HALT_40S_SEC = 40;
  localparam longint HALT_3S_SEC = 3;
  localparam longint TUNE_MAX_MS = 500;
  localparam longint HALT_20S_CYC = HALT_20S_SEC * CLK_HZ;
  localparam longint HALT_40S_CYC = HALT_40S_SEC * CLK_HZ;
  localparam longint HALT_3S_CYC = HALT_3S_SEC * CLK_HZ;
  localparam longint TUNE_MAX_CYC = TUNE_MAX_MS * CLK_HZ / 1000;
endpackage

// ---- otp_sensor_option_banks.sv ----
`timescale 1ns/10ps
module otp_sensor_option_banks #(
  parameter longint HALT_20S_N = otp_opt_pkg::HALT_20S_CYC, // 20 s in cycles
  parameter longint HALT_40S_N = otp_opt_pkg::HALT_40S_CYC, // 40 s in cycles
  parameter longint HALT_3S_N = otp_opt_pkg::HALT_3S_CYC,   // 3 s in cycles
  parameter longint TUNE_N = otp_opt_pkg::TUNE_MAX_CYC      // tuning timeout
) (
  input wire logic i_sys_clk,            // system clock 125 MHz
  input wire logic i_rst_b,              // async reset, active low
  input wire logic i_ce,                 // clock enable
  input wire logic [7:0] i_addr,         // register address
  input wire logic [7:0] i_wdata,        // write data
  input wire logic i_wr,                 // write strobe
  input wire logic i_rd,                 // read strobe
  output logic [7:0] o_rdata,            // read data, one cycle later
  input wire logic i_tune_done,          // tuning engine finished
  input wire logic i_touch_det,          // raw touch detect from engine
  input wire logic i_prox_det,           // raw proximity detect from engine
  output logic o_touch_indicator_out,    // touch pin level
  output logic o_touch_indicator_oe,     // touch pin enable
  input wire logic i_prox_out_or_control_in, // pin level sampled
  output logic o_prox_out_or_control_out,    // pin drive level
  output logic o_prox_out_or_control_oe,     // pin drive enable
  output logic o_cfg_valid,              // options latched
  output logic o_filter_halt,            // long-term average frozen
  output logic o_release_fraction_select,// release threshold option
  output logic [2:0] o_touch_level_select, // touch threshold option
  output logic [1:0] o_proximity_level_select, // proximity threshold option
  output logic o_fast_recalibration,     // fast recalibration, full tuning only
  output logic [2:0] o_base_value,       // base value, full tuning only
  output logic o_partial_tuning          // tuning mode
);
  import otp_opt_pkg::*;

  typedef enum logic [1:0] {ST_LOAD, ST_TUNE, ST_RUN} phase_t;

  logic [7:0] bank0_r, bank1_r, bank2_r;
  logic [7:0] cfg0_r, cfg1_r, cfg2_r;
  phase_t phase_r;
  logic [31:0] tune_cnt_r;
  logic [39:0] halt_cnt_r;
  logic halt_exp_r;
  logic prox_r;

  function automatic logic [39:0] halt_limit(input logic [1:0] code);
    case (code)
      HALT_20S: halt_limit = 40'(HALT_20S_N);
      HALT_40S: halt_limit = 40'(HALT_40S_N);
      HALT_3S: halt_limit = 40'(HALT_3S_N);
      default: halt_limit = '0;
    endcase
  endfunction

  // otp image: programmed once by the tool, zero means unprogrammed default
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bank0_r <= BANK0_RST;
      bank1_r <= BANK1_RST;
      bank2_r <= BANK2_RST;
    end else if (i_ce && i_wr && phase_r == ST_LOAD) begin
      case (i_addr)
        OFF_BANK0: bank0_r <= i_wdata;
        OFF_BANK1: bank1_r <= i_wdata & B1_USED_MASK;
        OFF_BANK2: bank2_r <= i_wdata & B2_USED_MASK;
        default: ;
      endcase
    end
  end

  // programming only before release; a write to OFF_CTRL bit 0 latches the banks and starts tuning
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_r <= ST_LOAD;
      cfg0_r <= BANK0_RST;
      cfg1_r <= BANK1_RST;
      cfg2_r <= BANK2_RST;
      tune_cnt_r <= '0;
    end else if (i_ce) begin
      case (phase_r)
        ST_LOAD: begin
          if (i_wr && i_addr == OFF_CTRL && i_wdata[0]) begin
            cfg0_r <= bank0_r;
            cfg1_r <= bank1_r;
            cfg2_r <= bank2_r;
            phase_r <= ST_TUNE;
          end
        end
        ST_TUNE: begin
          tune_cnt_r <= tune_cnt_r + 32'd1;
          if (i_tune_done || tune_cnt_r >= 32'(TUNE_N) - 32'd1) begin
            phase_r <= ST_RUN;
          end
        end
        ST_RUN: ;
        default: phase_r <= ST_LOAD;
      endcase
    end
  end

  logic full_tune;
  logic [1:0] halt_code;
  logic active_high;
  logic pin_is_input;
  assign full_tune = ~cfg2_r[B2_TUNE];
  assign halt_code = full_tune ? cfg1_r[B1_HALT_LO +: 2] : HALT_20S;
  assign active_high = cfg0_r[B0_POL];
  assign pin_is_input = cfg0_r[B0_DIR];

  // halt timer: runs while proximity holds; never-code stops it in full tuning so the halt never expires
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      halt_cnt_r <= '0;
      halt_exp_r <= 1'b0;
    end else if (i_ce) begin
      if (phase_r != ST_RUN || !i_prox_det) begin
        halt_cnt_r <= '0;
        halt_exp_r <= 1'b0;
      end else if (halt_code != HALT_NEVER && !halt_exp_r) begin
        halt_cnt_r <= halt_cnt_r + 40'd1;
        if (halt_cnt_r >= halt_limit(halt_code) - 40'd1) begin
          halt_exp_r <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prox_r <= 1'b0;
    end else if (i_ce) begin
      prox_r <= (phase_r == ST_RUN) && i_prox_det;
    end
  end

  logic touch_act;
  assign touch_act = phase_r == ST_RUN && (i_touch_det || (i_prox_det && !halt_exp_r));
  assign o_filter_halt = phase_r == ST_RUN && i_prox_det && !halt_exp_r;

  // active-low is open drain so the pin is released, not driven, when idle
  always_comb begin
    if (active_high) begin
      o_touch_indicator_out = (phase_r != ST_RUN) | touch_act;
      o_touch_indicator_oe = 1'b1;
      // input mode releases the pin, so it must not show a drive level either
      o_prox_out_or_control_out = !pin_is_input && ((phase_r != ST_RUN) | prox_r);
      o_prox_out_or_control_oe = !pin_is_input;
    end else begin
      o_touch_indicator_out = 1'b0;
      o_touch_indicator_oe = touch_act;
      o_prox_out_or_control_out = 1'b0;
      o_prox_out_or_control_oe = !pin_is_input && prox_r;
    end
  end

  assign o_cfg_valid = phase_r != ST_LOAD;
  assign o_release_fraction_select = cfg0_r[B0_REL];
  assign o_touch_level_select = cfg0_r[B0_TTHR_LO +: 3];
  assign o_proximity_level_select = cfg0_r[B0_PTHR_LO +: 2];
  assign o_fast_recalibration = full_tune & cfg1_r[B1_FAST];
  assign o_base_value = full_tune ? cfg1_r[B1_BASE_LO +: 3] : 3'h0;
  assign o_partial_tuning = cfg2_r[B2_TUNE];

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      if (i_rd) begin
        case (i_addr)
          OFF_BANK0: o_rdata <= bank0_r;
          OFF_BANK1: o_rdata <= bank1_r;
          OFF_BANK2: o_rdata <= bank2_r;
          OFF_STATUS: o_rdata <= {4'h0, i_prox_out_or_control_in, halt_exp_r, phase_r};
          default: o_rdata <= 8'h00;
        endcase
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end
endmodule

// ---- otp_opt_checker.sv ----
`timescale 1ns/10ps
module otp_opt_checker (
  input wire logic i_sys_clk, // clock
  input wire logic i_rst_b, // reset
  input wire logic o_touch_indicator_out, // level
  input wire logic o_touch_indicator_oe, // enable
  input wire logic o_prox_out_or_control_out, // level
  input wire logic o_prox_out_or_control_oe, // enable
  input wire logic o_cfg_valid, // latched
  input wire logic o_fast_recalibration, // fast
  input wire logic [2:0] o_base_value, // base
  input wire logic o_partial_tuning // mode
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_run_high;
    o_cfg_valid && o_touch_indicator_out;
  endsequence
  a_shared_pol: assert property (o_prox_out_or_control_oe && o_prox_out_or_control_out |-> o_touch_indicator_oe)
    else $error("prox driven high, touch floating");
  a_touch_driven: assert property (o_touch_indicator_out |-> o_touch_indicator_oe)
    else $error("touch high not driven");
  a_prox_driven: assert property (o_prox_out_or_control_out |-> o_prox_out_or_control_oe)
    else $error("prox high not driven");
  a_run_driven: assert property (s_run_high |=> o_touch_indicator_oe)
    else $error("touch released in active-high run");
  a_load_high: assert property (!o_cfg_valid && o_touch_indicator_oe |-> o_touch_indicator_out)
    else $error("touch not high before tuning");
  a_partial_zero: assert property (o_partial_tuning |-> !o_fast_recalibration && o_base_value == 3'h0)
    else $error("tuning fields used in partial mode");
  a_valid_sticky: assert property (o_cfg_valid |=> o_cfg_valid)
    else $error("latched flag dropped");
  a_cfg_frozen: assert property (o_cfg_valid |=> $stable({o_fast_recalibration, o_base_value, o_partial_tuning}))
    else $error("latched options changed");
endmodule

// ---- tune_engine_model.sv ----
`timescale 1ns/10ps
module tune_engine_model (
  input wire logic i_sys_clk, // clock
  input wire logic i_rst_b, // reset
  input wire logic i_cfg_valid, // options latched
  input wire logic [7:0] i_delay, // tuning length
  output logic o_tune_done // tuning finished
);
  logic [7:0] cnt_r;
  // a long delay lets the design's own timeout end tuning first
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= 8'h00;
      o_tune_done <= 1'b0;
    end else if (i_cfg_valid && !o_tune_done) begin
      cnt_r <= cnt_r + 8'h01;
      o_tune_done <= (cnt_r == i_delay);
    end
  end
endmodule

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
  import otp_opt_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, tdet = 1'b0, pdet = 1'b0;
  logic done, t_out, t_oe, p_out, p_oe, valid, fhalt, rel, fast, part;
  logic [7:0] addr = 8'h00, wdata = 8'h00, dly = 8'h04, rdata;
  logic [2:0] tlev, base;
  logic [1:0] plev;
  int err_count = 0, comparisons = 0;
  wire pin = p_oe ? p_out : 1'b1; // pull-up on the shared pin
  always #4 clk = ~clk;
  otp_sensor_option_banks #(.HALT_20S_N(20), .HALT_40S_N(40), .HALT_3S_N(3), .TUNE_N(10)) dut_u (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_tune_done(done), .i_touch_det(tdet), .i_prox_det(pdet), .o_touch_indicator_out(t_out),
    .o_touch_indicator_oe(t_oe), .i_prox_out_or_control_in(pin), .o_prox_out_or_control_out(p_out),
    .o_prox_out_or_control_oe(p_oe), .o_cfg_valid(valid), .o_filter_halt(fhalt), .o_release_fraction_select(rel),
    .o_touch_level_select(tlev), .o_proximity_level_select(plev), .o_fast_recalibration(fast),
    .o_base_value(base), .o_partial_tuning(part));
  tune_engine_model model_u (.i_sys_clk(clk), .i_rst_b(rst_b), .i_cfg_valid(valid), .i_delay(dly), .o_tune_done(done));
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", exp, rdata);
  endtask
  task start(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    wreg(OFF_BANK0, b0);
    wreg(OFF_BANK1, b1);
    wreg(OFF_BANK2, b2);
    wreg(OFF_CTRL, 8'h01);
    @(negedge clk);
    chk("cfg_valid", 8'h01, valid);
    chk("touch_out", 8'h01, t_out);
  endtask
  task wait_done;
    for (int i = 0; i < 40 && !done; i++) @(negedge clk);
    chk("tune_done", 8'h01, done);
    if (done !== 1'b1)
      test_done;
  endtask
  task t_defaults;
    rchk(OFF_BANK0, BANK0_RST);
    rchk(OFF_BANK1, BANK1_RST);
    rchk(OFF_BANK2, BANK2_RST);
    rchk(8'h80, 8'h00);
    chk("touch_oe", 8'h00, t_oe);
    $display("defaults done");
  endtask
  task t_program;
    dly <= 8'h04;
    start(8'h7e, 8'hfd, 8'h00);
    chk("release", 8'h01, rel);
    chk("touch_level", 8'h07, tlev);
    chk("prox_level", 8'h02, plev);
    chk("fast", 8'h01, fast);
    chk("base", 8'h05, base);
    rchk(OFF_BANK1, 8'hcd);
    wreg(OFF_BANK0, 8'h00);
    rchk(OFF_BANK0, 8'h7e);
    wait_done;
    cyc(2);
    rchk(OFF_STATUS, 8'h02);
    @(posedge clk);
    tdet <= 1'b1;
    cyc(2);
    chk("touch_on", 8'h01, t_out);
    tdet <= 1'b0;
    cyc(2);
    chk("touch_off", 8'h02, {t_oe, t_out});
    $display("program done");
  endtask
  task t_halt(input logic [7:0] b1, input logic [7:0] b2, input int n, input logic stays);
    dly <= 8'h1e;
    start(8'h20, b1, b2);
    chk("partial", {7'h00, b2[2]}, part);
    chk("fast", b2[2] ? 8'h00 : {7'h00, b1[3]}, fast);
    wait_done;
    @(posedge clk);
    pdet <= 1'b1;
    cyc(n - 2);
    @(negedge clk);
    chk("halt_on", 8'h03, {fhalt, t_out});
    cyc(5);
    @(negedge clk);
    chk("halt_end", {6'h00, stays, stays}, {fhalt, t_out});
    @(posedge clk);
    pdet <= 1'b0;
    $display("halt code done");
  endtask
  initial begin
    cyc(2);
    rst_b <= 1'b1;
    t_defaults;
    t_program;
    t_halt(8'h00, 8'h00, 20, 1'b0);
    t_halt(8'h40, 8'h00, 40, 1'b0);
    t_halt(8'h80, 8'h00, 60, 1'b1);
    t_halt(8'hc0, 8'h00, 3, 1'b0);
    t_halt(8'hcf, 8'h04, 20, 1'b0);
    test_done;
  end
endmodule
bind otp_sensor_option_banks otp_opt_checker chk_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
  .o_touch_indicator_out(o_touch_indicator_out), .o_touch_indicator_oe(o_touch_indicator_oe),
  .o_prox_out_or_control_out(o_prox_out_or_control_out), .o_prox_out_or_control_oe(o_prox_out_or_control_oe),
  .o_cfg_valid(o_cfg_valid), .o_fast_recalibration(o_fast_recalibration), .o_base_value(o_base_value),
  .o_partial_tuning(o_partial_tuning));
